//--- inc/chain_pkg.sv
/*
 constants and types shared by both ends of the chained serial link.
 assumes mclk at 10 MHz; the host end makes the link clock from it.
*/
package chain_pkg;
    // word framing
    localparam int WORD_BITS = 24;
    localparam logic [4:0] BIT_FIRST = 5'h00;
    localparam logic [4:0] BIT_LAST = 5'h17;
    localparam logic [4:0] BIT_RELAY = 5'h18;
    localparam int DELAY_BITS = 23;
    localparam int CONV_CMD_BIT = 23;
    localparam int DEV_W = 6;
    localparam logic [DEV_W-1:0] DEV_ONE = 6'h01;
    ////////////////////////////////////////////////////////////////
    // timing
    localparam int MCLK_NS = 100;
    localparam int SCLK_NS = 800;
    localparam int SCLK_HALF = SCLK_NS / (2 * MCLK_NS);
    localparam logic [2:0] HALF_LAST = 3'(SCLK_HALF - 1);
    localparam int CNV_LOW_NS = 400;
    localparam int CNV_LOW_CYC = (CNV_LOW_NS + MCLK_NS - 1) / MCLK_NS;
    localparam logic [2:0] CNV_LAST = 3'(CNV_LOW_CYC - 1);
    ////////////////////////////////////////////////////////////////
    // buffering and reset values
    localparam int BUF_DEPTH = 2;
    localparam logic [4:0] BIT_RST = 5'h00;
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam logic [WORD_BITS-1:0] WORD_RST = 24'h000000;
    ////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SETUP = 3'b001,
        H_LOW = 3'b010,
        H_HIGH = 3'b011,
        H_PUSH = 3'b100,
        H_END = 3'b101
    } host_state_t;
endpackage

//--- inc/chain_if.sv
/*
 pins between the host and the chain-head device.
 assumes the bench joins one host end and one device end to it.
*/
`timescale 1ns/1ps
`default_nettype none
interface chain_if;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic sdo;
    logic convert_start_pin;
    modport host (output cs_n, output sclk, output sdi, output convert_start_pin, input sdo);
    modport device (input cs_n, input sclk, input sdi, input convert_start_pin, output sdo);
endinterface
`default_nettype wire

//--- verilog/pair_buffer.sv
/*
 small word buffer with valid and ready on both sides.
 assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
    parameter int W = 24,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] count_q, count_d;
    logic push, pop;

    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_q[rd_q];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            always_comb begin
                mem_d[i] = mem_q[i];
                if (push && wr_q == AW'(i)) begin
                    mem_d[i] = in_data;
                end
            end
            always_ff @(posedge mclk) begin
                mem_q[i] <= mem_d[i];
            end
        end
    endgenerate

    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        count_d = count_q;
        if (push) begin
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            count_q <= count_d;
            in_ready <= (count_d != (AW + 1)'(DEPTH));
            out_valid <= (count_d != '0);
        end
    end
endmodule
`default_nettype wire

//--- verilog/chain_host.sv
/*
 host end: frames words, makes the link clock by division, buffers reads.
 assumes the device end samples and shifts on the falling link clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module chain_host (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // link
    chain_if.host link,
    // command side
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [chain_pkg::WORD_BITS-1:0] cmd_wdata,
    input wire logic [chain_pkg::DEV_W-1:0] cmd_devices,
    input wire logic conv_req,
    // read words
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [chain_pkg::WORD_BITS-1:0] rd_data
);
    import chain_pkg::*;
    host_state_t state_q, state_d;
    logic [2:0] cnt_q, cnt_d, cnv_cnt_q, cnv_cnt_d;
    logic [4:0] bit_q, bit_d;
    logic [DEV_W-1:0] left_q, left_d;
    logic [WORD_BITS-1:0] tx_q, tx_d, rx_q, rx_d;
    logic cs_n_q, cs_n_d, sclk_q, sclk_d, sdi_q, sdi_d;
    logic cnv_q, cnv_d, sdo_s1_q, sdo_s2_q;
    logic half, buf_ready;

    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
    assign link.sdi = sdi_q;
    assign link.convert_start_pin = cnv_q;
    assign half = (cnt_q == HALF_LAST);

    pair_buffer #(.W(WORD_BITS), .DEPTH(BUF_DEPTH)) pair_buffer_i (
        .mclk(mclk),
        .rst(rst),
        .in_valid(state_q == H_PUSH),
        .in_data(rx_q),
        .in_ready(buf_ready),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    ////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        left_d = left_q;
        tx_d = tx_q;
        rx_d = rx_q;
        cs_n_d = cs_n_q;
        sclk_d = sclk_q;
        sdi_d = sdi_q;
        cnt_d = (state_q == H_IDLE || state_q == H_PUSH || half) ? CNT_RST : cnt_q + 3'h1;
        unique case (state_q)
            H_IDLE: begin
                if (cmd_valid) begin
                    cs_n_d = 1'b0;
                    tx_d = cmd_wdata;
                    sdi_d = cmd_wdata[WORD_BITS-1];
                    left_d = cmd_devices;
                    bit_d = BIT_FIRST;
                    state_d = H_SETUP;
                end
            end
            H_SETUP, H_HIGH: begin
                if (half) begin
                    sclk_d = 1'b0;
                    state_d = H_LOW;
                end
            end
            H_LOW: begin
                if (half) begin
                    sclk_d = 1'b1;
                    rx_d = {rx_q[WORD_BITS-2:0], sdo_s2_q};
                    tx_d = {tx_q[WORD_BITS-2:0], 1'b0};
                    sdi_d = tx_q[WORD_BITS-2];
                    bit_d = bit_q + 5'h01;
                    state_d = (bit_q == BIT_LAST) ? H_PUSH : H_HIGH;
                end
            end
            H_PUSH: begin
                // stalls the link clock while the buffer is full
                if (buf_ready) begin
                    bit_d = BIT_FIRST;
                    left_d = left_q - DEV_ONE;
                    state_d = (left_q <= DEV_ONE) ? H_END : H_HIGH;
                end
            end
            H_END: begin
                if (half) begin
                    cs_n_d = 1'b1;
                    state_d = H_IDLE;
                end
            end
            default: state_d = H_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= H_IDLE;
            cnt_q <= CNT_RST;
            bit_q <= BIT_RST;
            left_q <= '0;
            tx_q <= WORD_RST;
            rx_q <= WORD_RST;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b1;
            sdi_q <= 1'b0;
            cmd_ready <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            left_q <= left_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            cs_n_q <= cs_n_d;
            sclk_q <= sclk_d;
            sdi_q <= sdi_d;
            cmd_ready <= (state_d == H_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////
    // host drives convert start
    always_comb begin
        cnv_d = cnv_q;
        cnv_cnt_d = cnv_cnt_q;
        if (!cnv_q) begin
            if (cnv_cnt_q == CNT_RST) begin
                cnv_d = 1'b1;
            end else begin
                cnv_cnt_d = cnv_cnt_q - 3'h1;
            end
        end else if (conv_req) begin
            cnv_d = 1'b0;
            cnv_cnt_d = CNV_LAST;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnv_q <= 1'b1;
            cnv_cnt_q <= CNT_RST;
            sdo_s1_q <= 1'b0;
            sdo_s2_q <= 1'b0;
        end else begin
            cnv_q <= cnv_d;
            cnv_cnt_q <= cnv_cnt_d;
            sdo_s1_q <= link.sdo;
            sdo_s2_q <= sdo_s1_q;
        end
    end
endmodule
`default_nettype wire

//--- verilog/chain_device.sv
/*
 device end of the chained serial port: shifter on the link clock,
 word and convert-start handling on mclk.
 assumes the link clock stands still outside frames and is high at rest.
*/
`timescale 1ns/1ps
`default_nettype none
module chain_device (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // link toward host or lower device
    chain_if.device link,
    // role strap
    input wire logic head_sel,
    // words to send
    input wire logic [chain_pkg::WORD_BITS-1:0] tx_conv_data,
    input wire logic [chain_pkg::WORD_BITS-1:0] tx_reg_data,
    input wire logic tx_sel_reg,
    // received words and conversion start
    output logic [chain_pkg::WORD_BITS-1:0] rx_word,
    output logic rx_valid,
    output logic conv_start,
    // chain pins
    input wire logic chain_up_data_in,
    output logic chain_down_data_out,
    output logic chain_up_data_out,
    output logic chain_up_clock_out,
    output logic chain_up_convert_out
);
    import chain_pkg::*;

    // link domain
    logic [4:0] bit_q, bit_d;
    logic [WORD_BITS-2:0] rx_sh_q, rx_sh_d;
    logic [WORD_BITS-1:0] rx_hold_q, rx_hold_d, tx_sh_q, tx_sh_d;
    logic [DELAY_BITS-1:0] dl_q, dl_d;
    logic done_q, done_d, sdo_q, sdo_d, down_q, down_d, up_q, up_d;
    logic out_bit;
    // mclk domain
    logic [WORD_BITS-1:0] tx_q, tx_d, rx_word_d;
    logic cs_s1_q, cs_s2_q, done_s1_q, done_s2_q, done_p_q;
    logic cnv_s1_q, cnv_s2_q, cnv_p_q;
    logic rx_valid_d, conv_start_d, done_rise, cnv_fall;
    logic head_s1_q, head_s2_q;


    // clock relayed upward unchanged; a flop cannot carry a clock
    assign chain_up_clock_out = link.sclk;
    // head drives its output, followers hold it low
    assign link.sdo = sdo_q;
    assign chain_down_data_out = down_q;
    assign chain_up_data_out = up_q;

    ////////////////////////////////////////////////////////////////
    // link domain: falling edge of the link clock
    always_comb begin
        bit_d = bit_q;
        if (bit_q != BIT_RELAY) begin
            bit_d = bit_q + 5'h01;
        end
        // input from host or lower device
        rx_sh_d = {rx_sh_q[WORD_BITS-3:0], link.sdi};
        rx_hold_d = rx_hold_q;
        done_d = done_q;
        if (bit_q == BIT_LAST) begin
            rx_hold_d = {rx_sh_q, link.sdi};
            done_d = 1'b1;
        end

        dl_d = {dl_q[DELAY_BITS-2:0], chain_up_data_in};
        tx_sh_d = {tx_sh_q[WORD_BITS-2:0], 1'b0};
        if (bit_q == BIT_FIRST) begin
            out_bit = tx_q[WORD_BITS-1];
            tx_sh_d = {tx_q[WORD_BITS-2:0], 1'b0};
        end else if (bit_q == BIT_RELAY) begin
            out_bit = dl_q[DELAY_BITS-1];
        end else begin
            out_bit = tx_sh_q[WORD_BITS-1];
        end

        sdo_d = head_s2_q ? out_bit : 1'b0;
        down_d = head_s2_q ? 1'b0 : out_bit;
        // host stream relayed to the device above, one edge late per hop
        up_d = link.sdi;
    end

    // shifting only while low
    // no link clock between frames, so cs_n high is the only clear
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            bit_q <= BIT_RST;
            rx_sh_q <= '0;
            rx_hold_q <= WORD_RST;
            tx_sh_q <= WORD_RST;
            dl_q <= '0;
            done_q <= 1'b0;
            sdo_q <= 1'b0;
            down_q <= 1'b0;
            up_q <= 1'b0;
        end else begin
            bit_q <= bit_d;
            rx_sh_q <= rx_sh_d;
            rx_hold_q <= rx_hold_d;
            tx_sh_q <= tx_sh_d;
            dl_q <= dl_d;
            done_q <= done_d;
            sdo_q <= sdo_d;
            down_q <= down_d;
            up_q <= up_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // strap synchronised on mclk
    // synced on mclk so routing is known before the first link fall;
    // static strap, so the link domain reads it without a handshake
    always_ff @(posedge mclk) begin
        if (rst) begin
            head_s1_q <= 1'b0;
            head_s2_q <= 1'b0;
        end else begin
            head_s1_q <= head_sel;
            head_s2_q <= head_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // mclk domain
    assign done_rise = done_s2_q & ~done_p_q;
    assign cnv_fall = cnv_p_q & ~cnv_s2_q;

    always_comb begin
        tx_d = tx_q;
        rx_word_d = rx_word;
        rx_valid_d = done_rise;
        // word chosen between frames only; frozen while framed
        if (cs_s2_q) begin
            tx_d = tx_sel_reg ? tx_reg_data : tx_conv_data;
        end
        // held word is stable from its last bit to the frame end
        if (done_rise) begin
            rx_word_d = rx_hold_q;
        end
        conv_start_d = cnv_fall | (done_rise & rx_hold_q[CONV_CMD_BIT]);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_q <= WORD_RST;
            rx_word <= WORD_RST;
            rx_valid <= 1'b0;
            conv_start <= 1'b0;
            chain_up_convert_out <= 1'b1;
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_p_q <= 1'b0;
            cnv_s1_q <= 1'b1;
            cnv_s2_q <= 1'b1;
            cnv_p_q <= 1'b1;
        end else begin
            tx_q <= tx_d;
            rx_word <= rx_word_d;
            rx_valid <= rx_valid_d;
            conv_start <= conv_start_d;
            chain_up_convert_out <= cnv_s2_q;
            cs_s1_q <= link.cs_n;
            cs_s2_q <= cs_s1_q;
            done_s1_q <= done_q;
            done_s2_q <= done_s1_q;
            done_p_q <= done_s2_q;
            cnv_s1_q <= link.convert_start_pin;
            cnv_s2_q <= cnv_s1_q;
            cnv_p_q <= cnv_s2_q;
        end
    end
endmodule
`default_nettype wire

//--- verification/chain_monitor.sv
/*
 link checker on the host to head device pins.
 assumes sclk, cs_n, sdi and convert_start_pin are host flops on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module chain_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // link pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic convert_start_pin
);
    import chain_pkg::*;
    logic sclk_q;
    logic [7:0] falls_q;
    logic [7:0] falls_d;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // falls in a frame; cleared while deselected
    always_comb begin
        falls_d = falls_q;
        if (cs_n) begin
            falls_d = 8'h00;
        end else if (sclk_q && !sclk) begin
            falls_d = falls_q + 8'h01;
        end
    end
    always_ff @(posedge mclk) begin
        sclk_q <= sclk;
        falls_q <= falls_d;
    end
    ////////////////////////////////////////////////////////////////
    // clock still outside frames
    property p_idle_clock;
        cs_n |-> sclk;
    endproperty
    a_idle_clock: assert property (p_idle_clock)
        else $error("link clock low outside a frame");
    property p_frame_setup;
        $fell(cs_n) |-> sclk [*4] ##1 !sclk;
    endproperty
    a_frame_setup: assert property (p_frame_setup)
        else $error("first clock fall not four cycles after select");
    property p_low_half;
        $fell(sclk) |-> !sclk [*4] ##1 sclk;
    endproperty
    a_low_half: assert property (p_low_half)
        else $error("low half not four cycles");
    property p_high_half;
        $rose(sclk) |-> sclk [*4];
    endproperty
    a_high_half: assert property (p_high_half)
        else $error("high half shorter than four cycles");
    property p_sdi_steady;
        !sclk |-> $stable(sdi);
    endproperty
    a_sdi_steady: assert property (p_sdi_steady)
        else $error("data input moved while clock low");
    property p_sdo_at_fall;
        $changed(sdo) |-> $fell(sclk) || $rose(cs_n);
    endproperty
    a_sdo_at_fall: assert property (p_sdo_at_fall)
        else $error("data output moved away from a clock fall");
    property p_whole_words;
        $rose(cs_n) |-> falls_q != 8'h00 && (falls_q % 8'h18) == 8'h00;
    endproperty
    a_whole_words: assert property (p_whole_words)
        else $error("frame not a whole number of words");
    property p_frame_close;
        $rose(cs_n) |-> sclk && $past(sclk);
    endproperty
    a_frame_close: assert property (p_frame_close)
        else $error("frame closed with clock low");
    property p_convert_pulse;
        $fell(convert_start_pin) |-> !convert_start_pin [*4] ##1 convert_start_pin;
    endproperty
    a_convert_pulse: assert property (p_convert_pulse)
        else $error("convert pulse not four cycles");
endmodule
`default_nettype wire

//--- verification/daisy_chain_serial_port_test.sv
/*
 bench: host, head device and one follower chained above it.
 assumes the follower takes clock, data and convert from the head.
*/
`timescale 1ns/1ps
`default_nettype none
module daisy_chain_serial_port_test;
    import chain_pkg::*;
    logic mclk, rst, cmd_valid, cmd_ready, conv_req, rd_valid, rd_ready, tx_sel_reg;
    logic [WORD_BITS-1:0] cmd_wdata, rd_data, head_rx, up_rx;
    logic [WORD_BITS-1:0] head_conv = 24'hA5C3E1, head_reg = 24'h81F00F;
    logic [WORD_BITS-1:0] up_conv = 24'h5A3C1E, up_reg = 24'h7E0FF1;
    logic [DEV_W-1:0] cmd_devices;
    logic head_rx_v, up_rx_v, head_cs, up_cs, up_down;
    int n_errors = 0, n_checks = 0, n_cycles = 0, head_rx_n = 0, head_cv_n = 0, up_cv_n = 0;
    int up_rx_n = 0;
    logic [WORD_BITS-1:0] got_q[$];
    chain_if link();
    chain_if link_up();
    // frames reach the follower unchanged
    assign link_up.cs_n = link.cs_n;
    chain_host chain_host_i (.mclk(mclk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_wdata(cmd_wdata), .cmd_devices(cmd_devices),
        .conv_req(conv_req), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
    chain_device chain_device_i (.mclk(mclk), .rst(rst), .link(link), .head_sel(1'b1),
        .tx_conv_data(head_conv), .tx_reg_data(head_reg), .tx_sel_reg(tx_sel_reg),
        .rx_word(head_rx), .rx_valid(head_rx_v), .conv_start(head_cs),
        .chain_up_data_in(up_down), .chain_down_data_out(), .chain_up_data_out(link_up.sdi),
        .chain_up_clock_out(link_up.sclk), .chain_up_convert_out(link_up.convert_start_pin));
    // follower strapped low
    // top of chain: nothing above feeds the follower
    chain_device chain_device_up_i (.mclk(mclk), .rst(rst), .link(link_up), .head_sel(1'b0),
        .tx_conv_data(up_conv), .tx_reg_data(up_reg), .tx_sel_reg(tx_sel_reg),
        .rx_word(up_rx), .rx_valid(up_rx_v), .conv_start(up_cs), .chain_up_data_in(1'b0),
        .chain_down_data_out(up_down), .chain_up_data_out(), .chain_up_clock_out(),
        .chain_up_convert_out());
    chain_monitor chain_monitor_i (.mclk(mclk), .rst(rst), .cs_n(link.cs_n),
        .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo), .convert_start_pin(link.convert_start_pin));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // words and pulses collected at the edge, hang guard
    always @(posedge mclk) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            got_q.push_back(rd_data);
        end
        head_rx_n += int'(head_rx_v === 1'b1);
        head_cv_n += int'(head_cs === 1'b1);
        up_cv_n += int'(up_cs === 1'b1);
        up_rx_n += int'(up_rx_v === 1'b1);
        n_cycles++;
        if (n_cycles == 20000) begin
            n_errors++;
            $display("unexpected at %0t: run too long", $time);
            finish_test();
        end
    end
    task automatic check(input logic [WORD_BITS-1:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic start_frame(input logic [WORD_BITS-1:0] w, input logic [DEV_W-1:0] n);
        for (int i = 0; i < 100 && cmd_ready !== 1'b1; i++) begin
            @(negedge mclk);
        end
        got_q = {};
        cmd_wdata = w;
        cmd_devices = n;
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        for (int i = 0; i < 10 && link.cs_n !== 1'b0; i++) begin
            @(negedge mclk);
        end
    endtask
    task automatic end_frame();
        for (int i = 0; i < 3000 && link.cs_n !== 1'b1; i++) begin
            @(negedge mclk);
        end
        repeat (8) @(negedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic test_conv_word();
        int rx0 = head_rx_n;
        int cv0 = head_cv_n;
        tx_sel_reg = 1'b0;
        start_frame(24'h3C5A96, 6'h01);
        end_frame();
        check(24'(got_q.size()), 24'h000001, "word count");
        check(got_q[0], head_conv, "head conversion word");
        check(head_rx, 24'h3C5A96, "head received word");
        check(24'(head_rx_n - rx0), 24'h000001, "head receive pulses");
        check(24'(head_cv_n - cv0), 24'h000000, "head converts");
        $display("test_conv_word done");
    endtask
    task automatic test_reg_chain();
        int r0 = up_rx_n;
        tx_sel_reg = 1'b1;
        start_frame(24'h6E2B94, 6'h02);
        end_frame();
        check(24'(got_q.size()), 24'h000002, "word count");
        check(got_q[0], head_reg, "head register word");
        check(got_q[1], up_reg, "relayed register word");
        check(up_rx, 24'h3715CA, "follower received word");
        check(24'(up_rx_n - r0), 24'h000001, "follower receive pulses");
        $display("test_reg_chain done");
    endtask
    task automatic test_serial_conv();
        int h0 = head_cv_n;
        int u0 = up_cv_n;
        tx_sel_reg = 1'b0;
        start_frame(24'h800001, 6'h01);
        end_frame();
        check(24'(head_cv_n - h0), 24'h000001, "head serial convert");
        check(24'(up_cv_n - u0), 24'h000000, "follower convert");
        check(up_rx, 24'h400000, "follower received word");
        $display("test_serial_conv done");
    endtask
    task automatic test_pin_conv();
        int h0 = head_cv_n;
        int u0 = up_cv_n;
        conv_req = 1'b1;
        @(negedge mclk);
        conv_req = 1'b0;
        for (int i = 0; i < 60 && up_cv_n == u0; i++) begin
            @(negedge mclk);
        end
        repeat (4) @(negedge mclk);
        check(24'(head_cv_n - h0), 24'h000001, "head pin convert");
        check(24'(up_cv_n - u0), 24'h000001, "follower pin convert");
        $display("test_pin_conv done");
    endtask
    task automatic test_stall();
        rd_ready = 1'b0;
        start_frame(24'h123456, 6'h03);
        repeat (900) @(negedge mclk);
        check(24'(got_q.size()), 24'h000000, "words while stalled");
        check(24'(link.cs_n), 24'h000000, "frame held open");
        rd_ready = 1'b1;
        end_frame();
        check(24'(got_q.size()), 24'h000003, "word count");
        check(got_q[0], head_conv, "head word");
        check(got_q[1], up_conv, "follower word");
        check(got_q[2], 24'h000000, "empty top word");
        $display("test_stall done");
    endtask
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_wdata = 24'h000000;
        cmd_devices = 6'h01;
        conv_req = 1'b0;
        rd_ready = 1'b1;
        tx_sel_reg = 1'b0;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        test_conv_word();
        test_reg_chain();
        test_serial_conv();
        test_pin_conv();
        test_stall();
        finish_test();
    end
endmodule
`default_nettype wire
